// ### rtl/mwrm_pkg.sv
package mwrm_pkg;
  // ----------------------------------------------------------------
  // widths and fixed slots
  // ----------------------------------------------------------------
  localparam int DW = 16;
  localparam int AW = 15;
  localparam logic [3:0] SLOT_SHIFT_CNT = 4'h0;
  localparam logic [3:0] SLOT_LINK = 4'hb;
  localparam logic [3:0] SLOT_BIT_BASE = 4'hc;
  localparam logic [3:0] SLOT_OLD_WP = 4'hd;
  localparam logic [3:0] SLOT_OLD_PC = 4'he;
  localparam logic [3:0] SLOT_OLD_ST = 4'hf;
  localparam int MASK_LSB = 12;
  localparam int BIT_BASE_LSB = 3;
  localparam int BIT_BASE_MSB = 14;
  localparam logic [15:0] WP_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] ST_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE, OP_LOAD_WP, OP_ALU, OP_SHIFT, OP_BRANCH_LINK, OP_CONTEXT,
    OP_RETURN, OP_BIT_OUT, OP_BIT_IN, OP_MEM2MEM, OP_INDEXED
  } mwrm_op_e;

  typedef enum logic [1:0] {
    SH_LEFT_ARITH, SH_RIGHT_ARITH, SH_RIGHT_LOG, SH_RIGHT_CIRC
  } mwrm_shift_e;

  typedef struct packed {
    mwrm_op_e op;
    mwrm_shift_e shift_kind;
    logic [3:0] slot;
    logic [3:0] slot_b;
    logic [3:0] shift_imm;
    logic [15:0] value;
    logic [15:0] value_b;
  } mwrm_cmd_s;

  typedef struct packed {
    logic [14:0] addr;
    logic [15:0] wdata;
    logic req;
    logic we;
  } mwrm_mem_s;

  function automatic logic [15:0] slot_addr(input logic [15:0] wp,
                                            input logic [3:0] n);
    slot_addr = 16'(wp + {11'h000, n, 1'b0});
  endfunction
endpackage

// ### rtl/mwrm_core.sv
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/10ps
// Behaviour
// RULE_01: workspace pointer addresses first of sixteen memory words used as registers.
// RULE_02: loading the pointer switches register sets at once, nothing copied.
// RULE_03: slots 1 to 15 may index a fixed address; slot 0 never indexes.
// RULE_04: shifts may take their count from slot 0.
// RULE_05: branch with link writes the return address into slot 11.
// RULE_06: serial bit base address comes from bits 3 to 14 of slot 12.
// RULE_07: return reloads pointer, counter and status from slots 13 to 15.
// RULE_08: program counter advances one word per instruction unless changed.
// RULE_09: status flags follow the latest arithmetic or logical result.
// RULE_10: status bits 12 to 15 hold the four-bit interrupt mask.
// RULE_11: 15-bit word address, 16-bit data, 32K words reachable.
// RULE_12: byte-select bit stays internal, never driven on the bus; the core drives it out on its BYTE_SEL port.
// RULE_13: two-operand ops read both from memory and write result back.
// RULE_14: address, control and data leave on separate outputs.
// RULE_15: serial bit I/O moves one bit at a time on its own bus.
// RULE_16: context switch: new pointer, store old st, pc, wp, then new pc.
// RULE_17: slot n lives at byte address pointer plus two times n.
module mwrm_core
  import mwrm_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire mwrm_cmd_s CMD,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  output logic [14:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  output logic MEM_REQ,
  output logic MEM_WE,
  input wire logic [15:0] MEM_RDATA,
  output logic [11:0] BIT_ADDR,
  output logic BIT_OUT,
  output logic BIT_STROBE,
  input wire logic BIT_IN,
  output logic [15:0] WP,
  output logic [15:0] PC,
  output logic [15:0] STATUS_WORD,
  output logic [3:0] INT_MASK,
  output logic BYTE_SEL
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_RD_A, S_RD_B, S_EXEC, S_WR, S_CTX_ST, S_CTX_PC, S_CTX_WP,
    S_RET_ST, S_RET_PC, S_RET_WP, S_BIT
  } mwrm_state_e;

  mwrm_state_e state;
  mwrm_cmd_s cmd;
  logic [15:0] wp;
  logic [15:0] pc;
  logic [15:0] st;
  logic [15:0] opa;
  logic [15:0] opb;
  logic [15:0] baddr;
  logic [15:0] old_wp;
  logic [15:0] old_pc;
  logic [15:0] old_st;
  logic [14:0] mem_addr;
  logic [15:0] mem_wdata;
  logic mem_req;
  logic mem_we;
  logic byte_sel;
  logic [11:0] bit_addr;
  logic bit_out;
  logic bit_strobe;
  logic [2:0] bit_in_sync;

  // ----------------------------------------------------------------
  // combinational helpers
  // ----------------------------------------------------------------
  wire logic [3:0] shift_cnt;
  wire logic [15:0] shift_res;
  wire logic [15:0] sum_res;
  wire logic [15:0] alu_res;
  wire logic [15:0] next_pc;
  wire logic [15:0] result_st;
  wire logic bit_in_stable;

  // slot 0 supplies the count only when no immediate is given
  assign shift_cnt = (cmd.shift_imm == 4'h0) ? opa[3:0]
                     : cmd.shift_imm; // [RULE_04]
  assign shift_res = shift16(opb, shift_cnt, cmd.shift_kind);
  assign sum_res = 16'(opa + opb);
  assign alu_res = (cmd.op == OP_SHIFT) ? shift_res : sum_res;
  assign next_pc = 16'(pc + 16'h0002); // [RULE_08]
  // flags sit below the mask so results never disturb it
  assign result_st = {st[15:12], alu_res != 16'h0000, alu_res == 16'h0000,
                      alu_res[15], st[8:0]}; // [RULE_09] [RULE_10]
  // only stage 2/3 agreement is trusted; stage 1 feeds stage 2 only
  assign bit_in_stable = (bit_in_sync[1] == bit_in_sync[2]);

  function automatic logic [15:0] shift16(input logic [15:0] v,
                                          input logic [3:0] n,
                                          input mwrm_shift_e k);
    logic [31:0] wide;
    wide = 32'h0000_0000;
    case (k)
      SH_LEFT_ARITH: shift16 = v << n;
      SH_RIGHT_ARITH: shift16 = 16'($signed(v) >>> n);
      SH_RIGHT_LOG: shift16 = v >> n;
      default: begin
        wide = {v, v} >> n;
        shift16 = wide[15:0];
      end
    endcase
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  task automatic mem_access(input logic [15:0] byte_addr,
                            input logic we, input logic [15:0] d);
    mem_addr <= byte_addr[15:1]; // [RULE_11] [RULE_17]
    byte_sel <= byte_addr[0]; // [RULE_12]
    mem_req <= 1'b1;
    mem_we <= we;
    mem_wdata <= d;
  endtask

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= S_IDLE;
      cmd <= '0;
      wp <= WP_RESET;
      pc <= PC_RESET;
      st <= ST_RESET;
      opa <= 16'h0000;
      opb <= 16'h0000;
      baddr <= 16'h0000;
      old_wp <= 16'h0000;
      old_pc <= 16'h0000;
      old_st <= 16'h0000;
      mem_addr <= 15'h0000;
      mem_wdata <= 16'h0000;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      byte_sel <= 1'b0;
      bit_addr <= 12'h000;
      bit_out <= 1'b0;
      bit_strobe <= 1'b0;
      bit_in_sync <= 3'h0;
    end else begin
      bit_in_sync <= {bit_in_sync[1:0], BIT_IN};
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      bit_strobe <= 1'b0;
      case (state)
        S_IDLE: begin
          if (CMD_VALID) begin
            cmd <= CMD;
            case (CMD.op)
              OP_LOAD_WP: begin
                wp <= CMD.value; // [RULE_02]
                pc <= next_pc;
              end
              OP_BRANCH_LINK: begin
                mem_access(slot_addr(wp, SLOT_LINK), 1'b1,
                           next_pc); // [RULE_05]
                pc <= CMD.value;
              end
              OP_CONTEXT: begin
                old_wp <= wp;
                old_pc <= pc;
                old_st <= st;
                wp <= CMD.value; // [RULE_16]
                state <= S_CTX_ST;
              end
              OP_RETURN: begin
                mem_access(slot_addr(wp, SLOT_OLD_ST), 1'b0,
                           16'h0000); // [RULE_07]
                state <= S_RET_ST;
              end
              OP_BIT_OUT, OP_BIT_IN: begin
                mem_access(slot_addr(wp, SLOT_BIT_BASE), 1'b0, 16'h0000);
                state <= S_RD_B;
              end
              OP_SHIFT: begin
                mem_access(slot_addr(wp, SLOT_SHIFT_CNT), 1'b0, 16'h0000);
                state <= S_RD_A;
              end
              OP_MEM2MEM, OP_ALU: begin
                mem_access(CMD.value, 1'b0, 16'h0000); // [RULE_13]
                state <= S_RD_A;
              end
              OP_INDEXED: begin
                // slot 0 as index means no index at all
                if (CMD.slot == 4'h0) begin // [RULE_03]
                  baddr <= CMD.value;
                  state <= S_EXEC;
                end else begin
                  mem_access(slot_addr(wp, CMD.slot), 1'b0, 16'h0000);
                  state <= S_RD_A;
                end
              end
              default: pc <= next_pc;
            endcase
          end
        end
        S_RD_A: begin
          opa <= MEM_RDATA;
          if (cmd.op == OP_INDEXED) begin
            baddr <= 16'(cmd.value + MEM_RDATA); // [RULE_03]
            state <= S_EXEC;
          end else if (cmd.op == OP_SHIFT) begin
            mem_access(slot_addr(wp, cmd.slot), 1'b0, 16'h0000);
            state <= S_RD_B;
          end else begin
            mem_access(cmd.value_b, 1'b0, 16'h0000); // [RULE_13]
            state <= S_RD_B;
          end
        end
        S_RD_B: begin
          opb <= MEM_RDATA;
          if (cmd.op == OP_BIT_OUT || cmd.op == OP_BIT_IN) begin
            bit_addr <= 12'(MEM_RDATA[BIT_BASE_MSB:BIT_BASE_LSB]
                            + {8'h00, cmd.shift_imm}); // [RULE_06]
            state <= S_BIT;
          end else begin
            state <= S_EXEC;
          end
        end
        S_EXEC: begin
          if (cmd.op == OP_INDEXED) begin
            // indexed result is the fetched operand address
            mem_access(baddr, 1'b0, 16'h0000);
            pc <= next_pc;
            state <= S_IDLE;
          end else begin
            st <= result_st; // [RULE_09]
            if (cmd.op == OP_SHIFT)
              mem_access(slot_addr(wp, cmd.slot), 1'b1, alu_res);
            else
              mem_access(cmd.value_b, 1'b1, alu_res); // [RULE_13]
            state <= S_WR;
          end
        end
        S_WR: begin
          pc <= next_pc; // [RULE_08]
          state <= S_IDLE;
        end
        S_BIT: begin
          // one bit per visit on the separate serial bus
          bit_strobe <= (cmd.op == OP_BIT_OUT); // [RULE_15]
          bit_out <= cmd.value[0];
          if (cmd.op == OP_BIT_IN && bit_in_stable) begin
            st <= {st[15:9], bit_in_sync[2], st[7:0]};
          end
          if (cmd.op == OP_BIT_OUT || bit_in_stable) begin
            pc <= next_pc;
            state <= S_IDLE;
          end
        end
        S_CTX_ST: begin
          mem_access(slot_addr(wp, SLOT_OLD_ST), 1'b1, old_st); // [RULE_16]
          state <= S_CTX_PC;
        end
        S_CTX_PC: begin
          mem_access(slot_addr(wp, SLOT_OLD_PC), 1'b1, old_pc); // [RULE_16]
          state <= S_CTX_WP;
        end
        S_CTX_WP: begin
          mem_access(slot_addr(wp, SLOT_OLD_WP), 1'b1, old_wp); // [RULE_16]
          pc <= cmd.value_b;
          state <= S_IDLE;
        end
        S_RET_ST: begin
          st <= MEM_RDATA; // [RULE_07]
          mem_access(slot_addr(wp, SLOT_OLD_PC), 1'b0, 16'h0000);
          state <= S_RET_PC;
        end
        S_RET_PC: begin
          pc <= MEM_RDATA; // [RULE_07]
          mem_access(slot_addr(wp, SLOT_OLD_WP), 1'b0, 16'h0000);
          state <= S_RET_WP;
        end
        S_RET_WP: begin
          wp <= MEM_RDATA; // [RULE_07]
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs: separate address, control, data [RULE_14]
  // ----------------------------------------------------------------
  assign CMD_READY = (state == S_IDLE);
  assign MEM_ADDR = mem_addr;
  assign MEM_WDATA = mem_wdata;
  assign MEM_REQ = mem_req;
  assign MEM_WE = mem_we;
  assign BIT_ADDR = bit_addr;
  assign BIT_OUT = bit_out;
  assign BIT_STROBE = bit_strobe;
  assign WP = wp; // [RULE_01]
  assign PC = pc;
  assign STATUS_WORD = st;
  assign INT_MASK = st[MASK_LSB +: 4]; // [RULE_10]
  assign BYTE_SEL = byte_sel;
endmodule

// ### test/mwrm_core_props.sv
`timescale 1ns/10ps
module mwrm_core_props
  import mwrm_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire mwrm_cmd_s CMD,
  input wire logic CMD_VALID,
  input wire logic CMD_READY,
  input wire logic [14:0] MEM_ADDR,
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic BIT_STROBE,
  input wire logic [15:0] WP,
  input wire logic [15:0] PC,
  input wire logic [15:0] STATUS_WORD,
  input wire logic [3:0] INT_MASK
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RESET);
  logic [15:0] cap;
  wire take = CMD_VALID && CMD_READY;
  wire wr = MEM_REQ && MEM_WE;
  wire rd = MEM_REQ && !MEM_WE;
  wire [14:0] cw = cap[15:1] + 15'h000f;
  wire [14:0] ww = WP[15:1] + 15'h000f;
  // operand of the last taken command, for later cycles
  always_ff @(posedge CLK) begin
    if (take) begin
      cap <= CMD.value;
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_mask_field: assert property (INT_MASK == STATUS_WORD[15:12])
    else $error("mask differs from status bits");
  a_mask_keep: assert property ($changed(INT_MASK) |-> $past(rd))
    else $error("mask changed without a status read");
  a_write_req: assert property (MEM_WE |-> MEM_REQ)
    else $error("write strobe without request");
  a_bit_pulse: assert property (BIT_STROBE |=> !BIT_STROBE)
    else $error("bit strobe longer than one cycle");
  a_load_wp: assert property (take && CMD.op == OP_LOAD_WP |=>
    WP == cap && PC == $past(PC) + 16'h0002)
    else $error("pointer load wrong");
  a_ctx_order: assert property (take && CMD.op == OP_CONTEXT |=>
    WP == cap ##[1:3] (wr && MEM_ADDR == cw) ##1
    (wr && MEM_ADDR == cw - 15'h1) ##1 (wr && MEM_ADDR == cw - 15'h2))
    else $error("context store order wrong");
  a_ret_read: assert property (take && CMD.op == OP_RETURN |->
    ##[1:2] (rd && MEM_ADDR == ww))
    else $error("return does not read last slot");
  a_link_slot: assert property (take && CMD.op == OP_BRANCH_LINK |->
    ##[1:3] (wr && MEM_ADDR == WP[15:1] + 15'h000b))
    else $error("link not written to slot 11");
  a_shift_cnt: assert property (take && CMD.op == OP_SHIFT &&
    CMD.shift_imm == 4'h0 |-> ##[1:2] (rd && MEM_ADDR == WP[15:1]))
    else $error("shift count not read from slot 0");
endmodule

bind mwrm_core mwrm_core_props mwrm_core_props_i (.*);

// ### test/mwrm_mem_model.sv
`timescale 1ns/10ps
module mwrm_mem_model
  import mwrm_pkg::*;
(
  input wire logic clk,
  input wire logic [14:0] addr,
  input wire logic [15:0] wdata,
  input wire logic req,
  input wire logic we,
  output logic [15:0] rdata,
  input wire logic [11:0] bit_addr,
  input wire logic bit_out,
  input wire logic bit_strobe,
  output logic bit_in
);
  // ----------------------------------------------------------------
  // word memory and bit peripherals
  // ----------------------------------------------------------------
  logic [15:0] mem [0:32767];
  logic [15:0] bits = 16'h0000;
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // plain always so the bench may poke words directly
  always @(posedge clk) begin
    if (req && we) begin
      mem[addr] <= wdata;
    end
    if (bit_strobe) begin
      bits[bit_addr[3:0]] <= bit_out;
    end
  end
  assign bit_in = bits[bit_addr[3:0]];
  // word stands only while the read request does; inverse otherwise
  assign rdata = (req && !we) ? mem[addr] : ~mem[addr];
endmodule

// ### test/tb.sv
`timescale 1ns/10ps
module tb
  import mwrm_pkg::*;
;
  typedef struct packed {
    logic [15:0] v;
    logic [15:0] wp;
    logic [15:0] pc;
  } mwrm_row_s;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  mwrm_cmd_s CMD = '0;
  logic CMD_VALID = 1'b0;
  logic CMD_READY, MEM_REQ, MEM_WE, BIT_OUT, BIT_STROBE, BIT_IN, BYTE_SEL;
  logic [14:0] MEM_ADDR;
  logic [15:0] MEM_WDATA, MEM_RDATA, WP, PC, STATUS_WORD;
  logic [15:0] old_pc, old_st, old_wp;
  logic [11:0] BIT_ADDR;
  logic [3:0] INT_MASK;
  logic [3:0] slot_sel = 4'h1;
  logic [14:0] last_rd = 15'h0000;
  int n_fail = 0;
  int n_checks = 0;
  mwrm_row_s rows [4] = '{'{16'h0100, 16'h0100, 16'h0002},
    '{16'h7ffe, 16'h7ffe, 16'h0004}, '{16'hfffe, 16'hfffe, 16'h0006},
    '{16'h0200, 16'h0200, 16'h0008}};
  mwrm_op_e ops [5] = '{OP_ALU, OP_BRANCH_LINK, OP_BIT_IN, OP_MEM2MEM,
    OP_INDEXED};
  always #25 CLK = ~CLK;
  mwrm_core mwrm_core_i (.*);
  mwrm_mem_model mwrm_mem_model_i (.clk(CLK), .addr(MEM_ADDR),
    .wdata(MEM_WDATA), .req(MEM_REQ), .we(MEM_WE), .rdata(MEM_RDATA),
    .bit_addr(BIT_ADDR), .bit_out(BIT_OUT), .bit_strobe(BIT_STROBE),
    .bit_in(BIT_IN));
  // last word address read, to see where an operand was fetched
  always @(posedge CLK) begin
    if (MEM_REQ && !MEM_WE)
      last_rd <= MEM_ADDR;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic final_report();
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // ready sampled mid-cycle, away from the edge that changes it
  task automatic wait_ready();
    int i;
    i = 0;
    @(negedge CLK);
    while (CMD_READY !== 1'b1) begin
      i++;
      if (i > 40) begin
        n_fail++;
        final_report();
      end
      @(negedge CLK);
    end
  endtask
  task automatic issue(input mwrm_op_e op, input logic [15:0] v,
                       input logic [15:0] vb);
    wait_ready();
    @(posedge CLK);
    CMD <= '{op, SH_LEFT_ARITH, slot_sel, 4'h2, 4'h0, v, vb};
    CMD_VALID <= 1'b1;
    wait_ready();
    @(posedge CLK);
    CMD_VALID <= 1'b0;
    @(posedge CLK);
    wait_ready();
    @(negedge CLK);
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge CLK);
    RESET <= 1'b0;
    @(negedge CLK);
    chk("reset wp", WP, WP_RESET);
    chk("reset pc", PC, PC_RESET);
    chk("reset st", STATUS_WORD, ST_RESET);
    chk("reset ready", {15'h0000, CMD_READY}, 16'h0001);
    foreach (rows[i]) begin
      issue(OP_LOAD_WP, rows[i].v, 16'h0000);
      chk("row wp", WP, rows[i].wp);
      chk("row pc", PC, rows[i].pc);
    end
    old_pc = PC;
    old_st = STATUS_WORD;
    old_wp = WP;
    issue(OP_CONTEXT, 16'h0400, 16'h1234);
    chk("ctx wp", WP, 16'h0400);
    chk("ctx pc", PC, 16'h1234);
    chk("slot15", mwrm_mem_model_i.mem[15'h020f], old_st);
    chk("slot14", mwrm_mem_model_i.mem[15'h020e], old_pc);
    chk("slot13", mwrm_mem_model_i.mem[15'h020d], old_wp);
    mwrm_mem_model_i.mem[15'h020f] = 16'ha000;
    issue(OP_RETURN, 16'h0000, 16'h0000);
    chk("ret wp", WP, old_wp);
    chk("ret pc", PC, old_pc);
    chk("ret st", STATUS_WORD, 16'ha000);
    chk("mask", {12'h000, INT_MASK}, 16'h000a);
    mwrm_mem_model_i.mem[15'h010c] = 16'h0af8;
    issue(OP_BIT_OUT, 16'h0001, 16'h0000);
    chk("bit addr", {4'h0, BIT_ADDR}, 16'h015f);
    chk("bit out", {15'h0000, mwrm_mem_model_i.bits[15]}, 16'h0001);
    old_pc = PC;
    issue(OP_SHIFT, 16'h0005, 16'h0000);
    chk("shift pc", PC, old_pc + 16'h0002);
    old_pc = PC;
    issue(OP_BRANCH_LINK, 16'h0300, 16'h0000);
    chk("link pc", PC, 16'h0300);
    chk("slot11", mwrm_mem_model_i.mem[15'h010b],
        old_pc + 16'h0002);
    mwrm_mem_model_i.mem[15'h0180] = 16'h8001;
    mwrm_mem_model_i.mem[15'h0181] = 16'h0001;
    issue(OP_ALU, 16'h0300, 16'h0302);
    chk("alu sum", mwrm_mem_model_i.mem[15'h0181], 16'h8002);
    chk("alu st", STATUS_WORD, 16'haa00);
    mwrm_mem_model_i.mem[15'h0182] = 16'h0003;
    issue(OP_MEM2MEM, 16'h0302, 16'h0304);
    chk("m2m sum", mwrm_mem_model_i.mem[15'h0182], 16'h8005);
    issue(OP_BIT_IN, 16'h0000, 16'h0000);
    chk("bit in st", STATUS_WORD, 16'hab00);
    slot_sel = 4'h0;
    issue(OP_INDEXED, 16'h0401, 16'h0000);
    chk("idx0 addr", {1'b0, last_rd}, 16'h0200);
    chk("idx0 byte", {15'h0000, BYTE_SEL}, 16'h0001);
    slot_sel = 4'h1;
    mwrm_mem_model_i.mem[15'h0101] = 16'h0010;
    issue(OP_INDEXED, 16'h0400, 16'h0000);
    chk("idx1 addr", {1'b0, last_rd}, 16'h0208);
    foreach (ops[i]) issue(ops[i], 16'h0005, 16'h0003);
    // reset again in mid-run: state must return to its reset values
    @(posedge CLK);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    @(negedge CLK);
    chk("rerst wp", WP, WP_RESET);
    chk("rerst st", STATUS_WORD, ST_RESET);
    issue(OP_LOAD_WP, 16'h0040, 16'h0000);
    chk("rerst pc", PC, PC_RESET + 16'h0002);
    final_report();
  end
endmodule
